/* logic/ccc_defs.svh */
/*
  Constants of the command-coil block: coil addresses, coil values,
  reset values. Assumes it is included by design files and by the bench.
*/
`ifndef CCC_DEFS_SVH
`define CCC_DEFS_SVH

// ----------------------------------------------------------------------
// Coil addresses
// ----------------------------------------------------------------------
`define CCC_COIL_DISCARD     16'h03F2
`define CCC_COIL_SINGLE      16'h03F3
`define CCC_COIL_FIRST       16'h03F4
`define CCC_COIL_SECOND      16'h03F5
`define CCC_COIL_FACTORY     16'h03F6
`define CCC_COIL_SAVE_MASS   16'h03F7
`define CCC_COIL_SAVE_VOL    16'h03F8
// Last coil whose read shows a running operation
`define CCC_COIL_LAST_STATUS 16'h03F6

// ----------------------------------------------------------------------
// Coil write values and reset values
// ----------------------------------------------------------------------
`define CCC_COIL_ON          16'hFF00
`define CCC_COIL_OFF         16'h0000
`define CCC_FIRST_DONE_RST   1'h0
`define CCC_START_RST        1'h0

`endif

/* logic/ccc_pkg.sv */
/*
  Types of the command-coil block: operation codes, engine states and
  the structs of the coil access port. Assumes nothing of its users.
*/
package ccc_pkg;

  // Operation code equals the coil offset from the discard coil
  typedef enum logic [2:0] {
    CCC_OP_DISCARD   = 3'b000,
    CCC_OP_SINGLE    = 3'b001,
    CCC_OP_FIRST     = 3'b010,
    CCC_OP_SECOND    = 3'b011,
    CCC_OP_FACTORY   = 3'b100,
    CCC_OP_SAVE_MASS = 3'b101,
    CCC_OP_SAVE_VOL  = 3'b110,
    CCC_OP_NONE      = 3'b111
  } ccc_op_e;

  typedef enum logic [1:0] {
    CCC_ST_IDLE  = 2'b00,
    CCC_ST_ISSUE = 2'b01,
    CCC_ST_WAIT  = 2'b10
  } ccc_state_e;

  // Decoded single-coil access from the serial front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] value;
  } ccc_coil_req_s;

  typedef struct packed {
    logic ack;
    logic refused;
    logic rdata;
  } ccc_coil_rsp_s;

endpackage

/* logic/ccc_op_engine.sv */
/*
  Operation engine: runs one coil operation at a time, issues a start
  pulse with its code and waits for the device's done pulse.
  Assumes the caller only starts it while it is idle.
*/
`timescale 1ns/1ps
`include "ccc_defs.svh"

module ccc_op_engine (
  input  wire logic            clk_i,       // 10 MHz clock
  input  wire logic            rst_i,       // Sync reset, active high
  input  wire logic            ce_i,        // Clock enable
  input  wire logic            start_i,     // Accepted command
  input  wire ccc_pkg::ccc_op_e op_i,       // Its operation
  input  wire logic            op_done_i,   // Device finished operation
  output ccc_pkg::ccc_op_e     run_op_o,    // Operation in hand
  output logic                 busy_o,      // Operation running
  output logic                 op_start_o,  // One-cycle start pulse
  output logic                 finish_o     // One-cycle finish pulse
);

  ccc_pkg::ccc_state_e state;
  ccc_pkg::ccc_state_e next_state;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ccc_pkg::CCC_ST_IDLE: begin
        if (start_i) next_state = ccc_pkg::CCC_ST_ISSUE;
      end
      ccc_pkg::CCC_ST_ISSUE: begin
        next_state = ccc_pkg::CCC_ST_WAIT;
      end
      ccc_pkg::CCC_ST_WAIT: begin
        if (op_done_i) next_state = ccc_pkg::CCC_ST_IDLE;
      end
      default: begin
        next_state = ccc_pkg::CCC_ST_IDLE;
      end
    endcase
  end

  wire launch = (state == ccc_pkg::CCC_ST_IDLE) && start_i;
  wire ending = (state == ccc_pkg::CCC_ST_WAIT) && op_done_i;

  // ----------------------------------------------------------------------
  // State and outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= ccc_pkg::CCC_ST_IDLE;
      run_op_o   <= ccc_pkg::CCC_OP_NONE;
      busy_o     <= 1'h0;
      op_start_o <= `CCC_START_RST;
      finish_o   <= 1'h0;
    end else if (ce_i) begin
      state      <= next_state;
      busy_o     <= (next_state != ccc_pkg::CCC_ST_IDLE);
      op_start_o <= launch;
      finish_o   <= ending;
      if (launch) run_op_o <= op_i;
    end
  end

endmodule

/* logic/ccc_coils.sv */
/*
  Command coils 1010 to 1016 of a flow converter: decodes single-coil
  writes and reads, starts discard, density calibration, factory restore
  and save operations, and reports running operations other than saves on read.
  Assumes a serial front end that delivers one decoded coil access per
  cycle and answers addresses outside this block itself.
*/
`timescale 1ns/1ps
`include "ccc_defs.svh"

module ccc_coils (
  input  wire logic                  clk_i,        // 10 MHz clock
  input  wire logic                  rst_i,        // Sync reset, active high
  input  wire logic                  ce_i,         // Clock enable
  input  wire ccc_pkg::ccc_coil_req_s coil_req_i,  // Decoded coil access
  input  wire logic                  op_done_i,    // Device finished op
  output ccc_pkg::ccc_coil_rsp_s     coil_rsp_o,   // Registered answer
  output ccc_pkg::ccc_op_e           op_code_o,    // Operation in hand
  output logic                       op_start_o,   // Start pulse
  output logic                       busy_o,       // Operation running
  output logic                       first_done_o  // First point held
);

  // ----------------------------------------------------------------------
  // Address and value decode
  // ----------------------------------------------------------------------
  wire               in_range;
  wire        [15:0] offs;
  wire               is_on;
  wire               is_off;
  wire               status_coil;
  ccc_pkg::ccc_op_e  req_op;
  ccc_pkg::ccc_op_e  run_op;
  wire               running;
  wire               finish;
  wire               second_blocked;
  wire               wr_hit;
  wire               rd_hit;
  wire               wr_accept;
  wire               wr_off;
  wire               wr_refuse;
  wire               rd_running;
  wire               clr_first;
  wire               set_first;
  wire               next_first;
  ccc_pkg::ccc_coil_rsp_s next_rsp;

  assign in_range = (coil_req_i.addr >= `CCC_COIL_DISCARD) &&
                    (coil_req_i.addr <= `CCC_COIL_SAVE_VOL);
  assign offs     = coil_req_i.addr - `CCC_COIL_DISCARD;
  assign req_op   = ccc_pkg::ccc_op_e'(offs[2:0]);
  assign is_on    = (coil_req_i.value == `CCC_COIL_ON);
  assign is_off   = (coil_req_i.value == `CCC_COIL_OFF);
  // Save coils are write only and never read as running
  assign status_coil = (coil_req_i.addr <= `CCC_COIL_LAST_STATUS);

  // ----------------------------------------------------------------------
  // Command acceptance
  // ----------------------------------------------------------------------
  // Second point needs a completed first point
  assign second_blocked = (req_op == ccc_pkg::CCC_OP_SECOND) &&
                          !first_done_o;
  assign wr_hit    = coil_req_i.wr && in_range;
  assign rd_hit    = coil_req_i.rd && in_range;
  // One operation at a time: a second command while busy is refused
  // rather than queued, so the master sees the clash at once.
  assign wr_accept = wr_hit && is_on && !running &&
                     !second_blocked;
  assign wr_off    = wr_hit && is_off;
  assign wr_refuse = wr_hit && ((!is_on && !is_off) ||
                     (is_on && (running || second_blocked)));
  assign rd_running = running && status_coil &&
                      (run_op == req_op);

  // One driver for the whole answer struct
  assign next_rsp = '{ack:     wr_accept || wr_off || rd_hit,
                      refused: wr_refuse,
                      rdata:   rd_hit && rd_running};

  // ----------------------------------------------------------------------
  // First-point record of the two-point calibration
  // ----------------------------------------------------------------------
  // A new single point, second point or factory restore ends the pair
  assign clr_first = wr_accept &&
                     ((req_op == ccc_pkg::CCC_OP_SECOND) ||
                      (req_op == ccc_pkg::CCC_OP_SINGLE) ||
                      (req_op == ccc_pkg::CCC_OP_FACTORY));
  assign set_first = finish && (run_op == ccc_pkg::CCC_OP_FIRST);
  // Set wins over clear
  assign next_first = set_first ? 1'h1 :
                      (clr_first ? 1'h0 : first_done_o);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_done_o <= `CCC_FIRST_DONE_RST;
      coil_rsp_o   <= '0;
    end else if (ce_i) begin
      first_done_o <= next_first;
      coil_rsp_o   <= next_rsp;
    end
  end

  // ----------------------------------------------------------------------
  // Operation engine
  // ----------------------------------------------------------------------
  // Op code equals coil offset: discard, single, first, second, factory,
  // save with mass, save with volume.
  ccc_op_engine u_engine (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .start_i    (wr_accept),
    .op_i       (req_op),
    .op_done_i  (op_done_i),
    .run_op_o   (run_op),
    .busy_o     (running),
    .op_start_o (op_start_o),
    .finish_o   (finish)
  );

  assign op_code_o = run_op;
  assign busy_o    = running;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_discard_start: assert property (
    ce_i && wr_accept && req_op == ccc_pkg::CCC_OP_DISCARD |=>
      op_start_o && op_code_o == ccc_pkg::CCC_OP_DISCARD)
    else $error("discard coil did not start discard");

  chk_single_start: assert property (
    ce_i && wr_hit && is_on && !running &&
    req_op == ccc_pkg::CCC_OP_SINGLE |=>
      $rose(op_start_o) && op_code_o == ccc_pkg::CCC_OP_SINGLE)
    else $error("single point calibration not started");

  chk_first_start: assert property (
    ce_i && wr_accept && req_op == ccc_pkg::CCC_OP_FIRST |=>
      busy_o && op_code_o == ccc_pkg::CCC_OP_FIRST)
    else $error("first point calibration not started");

  chk_second_start: assert property (
    ce_i && wr_hit && is_on && !running && first_done_o &&
    req_op == ccc_pkg::CCC_OP_SECOND |=>
      op_start_o && op_code_o == ccc_pkg::CCC_OP_SECOND
      && !first_done_o)
    else $error("second point calibration not started");

  chk_second_block: assert property (
    ce_i && wr_hit && is_on && !first_done_o &&
    req_op == ccc_pkg::CCC_OP_SECOND |=>
      !op_start_o && coil_rsp_o.refused && !coil_rsp_o.ack)
    else $error("second point accepted without first point");

  chk_first_record: assert property (
    ce_i && op_done_i && busy_o && !op_start_o &&
    op_code_o == ccc_pkg::CCC_OP_FIRST |=> !busy_o ##1 first_done_o)
    else $error("completed first point not recorded");

  chk_factory_start: assert property (
    ce_i && wr_accept && req_op == ccc_pkg::CCC_OP_FACTORY |=>
      op_start_o ##1 !op_start_o && busy_o)
    else $error("factory restore not started");

  chk_read_running: assert property (
    ce_i && rd_hit && busy_o && status_coil && req_op == op_code_o
    |=> coil_rsp_o.ack && coil_rsp_o.rdata)
    else $error("running operation read as 0");

  chk_read_idle: assert property (
    ce_i && rd_hit && !busy_o |=> coil_rsp_o.ack && !coil_rsp_o.rdata)
    else $error("idle coil read as 1");

  chk_save_mass: assert property (
    ce_i && wr_accept && req_op == ccc_pkg::CCC_OP_SAVE_MASS |=>
      op_start_o && op_code_o == ccc_pkg::CCC_OP_SAVE_MASS)
    else $error("save with mass total not started");

  chk_save_vol: assert property (
    ce_i && wr_accept && req_op == ccc_pkg::CCC_OP_SAVE_VOL |=>
      op_start_o && op_code_o == ccc_pkg::CCC_OP_SAVE_VOL)
    else $error("save with volume total not started");

  chk_off_inert: assert property (
    ce_i && wr_hit && is_off && !busy_o |=>
      !op_start_o && !busy_o && coil_rsp_o.ack)
    else $error("OFF write started an operation");

  cov_two_point: cover property (
    set_first ##[1:200] (wr_accept && req_op == ccc_pkg::CCC_OP_SECOND));
  cov_busy_read: cover property (rd_hit && rd_running);
  cov_busy_refuse: cover property (wr_refuse && running);
  cov_save_done: cover property (
    finish && run_op == ccc_pkg::CCC_OP_SAVE_VOL);

endmodule

/* tb/ccc_op_model.sv */
/*
  Model of the device side that carries out coil operations.
  Assumes op_start_i is a one-cycle pulse and delay_i is at least 1.
*/
`timescale 1ns/1ps

module ccc_op_model (
  input  wire logic       clk_i,      // Clock
  input  wire logic       rst_i,      // Sync reset, active high
  input  wire logic       op_start_i, // Operation start pulse
  input  wire logic [7:0] delay_i,    // Cycles until done
  output logic            op_done_o   // Operation done pulse
);
  logic [7:0] cnt;

  // Slow or prompt finish, chosen per operation by the bench
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cnt <= 8'h00;
    else if (op_start_i)
      cnt <= delay_i;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end

  assign op_done_o = (cnt == 8'h01);
endmodule

/* tb/ccc_coils_tb.sv */
/*
  Self-checking bench of the command coils: drives coil accesses,
  notes expected answers in a queue and checks them in a monitor.
  Assumes the device side is ccc_op_model.
*/
`timescale 1ns/1ps
`include "ccc_defs.svh"

module ccc_coils_tb;
  logic                   clk_i;
  logic                   rst_i;
  logic                   ce_i;
  ccc_pkg::ccc_coil_req_s req;
  ccc_pkg::ccc_coil_rsp_s rsp;
  ccc_pkg::ccc_op_e       code;
  logic                   op_start_o;
  logic                   busy_o;
  logic                   first_done_o;
  logic                   op_done;
  logic [7:0]             dly;
  logic [2:0]             exp_q[$];
  int                     bad_count;
  int                     n_tests;
  int                     cycles;
  int                     seed;

  ccc_coils DUT (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .coil_req_i   (req),
    .op_done_i    (op_done),
    .coil_rsp_o   (rsp),
    .op_code_o    (code),
    .op_start_o   (op_start_o),
    .busy_o       (busy_o),
    .first_done_o (first_done_o)
  );

  ccc_op_model partner (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .op_start_i (op_start_o),
    .delay_i    (dly),
    .op_done_o  (op_done)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [2:0] e, logic [2:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Every answer must match the oldest note; no note means no answer
  always @(posedge clk_i) begin
    #1;
    if (rsp.ack === 1'b1 || rsp.refused === 1'b1) begin
      if (exp_q.size() == 0)
        chk("unexpected_rsp", 3'b000, rsp);
      else
        chk("coil_rsp", exp_q.pop_front(), rsp);
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // Expected answer 3'b000 marks an access that gets no answer
  task automatic acc(logic w, logic [15:0] a, logic [15:0] v,
                     logic [2:0] e);
    @(posedge clk_i);
    #2;
    req = '{wr: w, rd: !w, addr: a, value: v};
    if (e != 3'b000)
      exp_q.push_back(e);
    @(posedge clk_i);
    #2;
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 100 && busy_o !== 1'b0; i++) begin
      @(posedge clk_i);
      #2;
    end
    chk("busy_end", 3'b000, {2'b00, busy_o});
  endtask

  // Delay of 3 or more keeps the op running over the next two accesses
  task automatic run_op(logic [2:0] op);
    dly = 8'(($unsigned($random(seed)) % 16) + 3);
    acc(1'b1, 16'h03F2 + 16'(op), `CCC_COIL_ON, 3'b100);
    chk("op_start", 3'b001, {2'b00, op_start_o});
    chk("op_code", op, code);
    acc(1'b0, 16'h03F2 + 16'(op), 16'h0000,
        (op < 3'd5) ? 3'b101 : 3'b100);
    acc(1'b1, 16'h03F2 + 16'(op), `CCC_COIL_ON, 3'b010);
    wait_idle();
    acc(1'b0, 16'h03F2 + 16'(op), 16'h0000, 3'b100);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    seed = 32'h0db79227;
    req = '0;
    ce_i = 1'b1;
    rst_i = 1'b1;
    dly = 8'h03;
    repeat (5) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    chk("reset_code", 3'b111, code);
    chk("reset_flags", 3'b000, {busy_o, first_done_o, op_start_o});
    acc(1'b1, `CCC_COIL_SECOND, `CCC_COIL_ON, 3'b010);
    acc(1'b1, `CCC_COIL_DISCARD, `CCC_COIL_OFF, 3'b100);
    chk("off_start", 3'b000, {busy_o, op_start_o, 1'b0});
    acc(1'b1, `CCC_COIL_SINGLE, {8'h5A, 8'($random(seed))},
        3'b010);
    acc(1'b1, 16'h03F1, `CCC_COIL_ON, 3'b000);
    acc(1'b0, 16'h03F9, 16'h0000, 3'b000);
    run_op(3'd0);
    run_op(3'd2);
    chk("first_set", 3'b001, {2'b00, first_done_o});
    // A single point ends a pending pair
    run_op(3'd1);
    chk("first_after_single", 3'b000, {2'b00, first_done_o});
    run_op(3'd2);
    // Mid-run reset drops the first-point record
    @(posedge clk_i);
    #2;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    chk("reset_mid", 3'b000, {busy_o, first_done_o, op_start_o});
    run_op(3'd2);
    chk("first_done", 3'b001, {2'b00, first_done_o});
    run_op(3'd3);
    chk("first_cleared", 3'b000, {2'b00, first_done_o});
    acc(1'b1, `CCC_COIL_SECOND, `CCC_COIL_ON, 3'b010);
    run_op(3'd4);
    run_op(3'd5);
    run_op(3'd6);
    // Clock enable low: a write is not taken and nothing moves
    @(posedge clk_i);
    #2;
    ce_i = 1'b0;
    acc(1'b1, `CCC_COIL_DISCARD, `CCC_COIL_ON, 3'b000);
    chk("frozen", 3'b000, {busy_o, op_start_o, first_done_o});
    ce_i = 1'b1;
    repeat (3) @(posedge clk_i);
    chk("queue_empty", 3'b000, 3'(exp_q.size()));
    give_verdict();
  end
endmodule
